// ==== rtl/ecc_event_ctrl.sv ====
// Purpose: event controller driving the load or auxiliary terminal
// Assumes: meas inputs synchronous to clock, minute_tick one cycle long
// Notes:   configuration and status over a classic Wishbone slave
//
// Function
// - Controller runs only at program level 4, else held off.
// - A terminal carries the event only with function setting 4 or 5.
// - Start code 1 solar below threshold, code 0 solar above.
// - Solar comparisons may lag the crossing by up to six minutes.
// - External threshold offset: 8.0 means 0 V, 0.1 V steps.
// - Push-button wired to battery negative, sense function set to 2.
// - Start 4 button on and time past; 5 button off and time past.
// - Start 8..11 repeat every 10m, 30m, 1h, 2h while time past.
// - Start 12 active while time of day exceeds setting.
// - Start 14/15 repeat at programmed rate in minutes or tenths hour.
// - Stop 0/1 solar above/below; stop 2/3 external above/below.
// - Stop 4 button off and time past; 5 button on and time past.
// - Stop 8..11 repeat every 1, 3, 6, 12 minutes while time past.
// - Stop 12 once time exceeds setting; above 23.9 never stops.
// - Stop 14/15 after programmed run time from the start.
// - Qualifier code zero means always active.
// - Operating qualifier 1 active only in float charging.
// - Off turns on with all three; on turns off on stop or qualifier.
// - Operating qualifier: 1 float, 2 night, 3 day, 5/6 float combos.
// - Measured codes 0..6 let battery disconnect override; 8..14 not.
`timescale 1ns/1ps

module ecc_event_ctrl
	import ecc_pkg::*;
#(
	parameter logic [10:0] SOLAR_PERIOD = ECC_SOLAR_MIN
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_ack_o,
	output logic [31:0]      wb_dat_o,
	// Regulator measurements
	input  wire ecc_meas_s   meas,
	// Terminals
	output ecc_term_s        term
);

	// Refused at elaboration: the refresh must stay within six minutes
	if (SOLAR_PERIOD == 11'h000 || SOLAR_PERIOD > ECC_SOLAR_MIN) begin : g_bad
		$error("SOLAR_PERIOD must be 1..6 minutes");
	end

	ecc_state_s st;
	ecc_state_s next_st;

	// ----------------------------------------
	// Configuration fields
	// ----------------------------------------
	logic [2:0] program_level;
	logic [3:0] load_fn, aux_fn, sense_fn;
	logic [3:0] start_code, stop_code, operating_state_qualifier, measured_qualifier;
	logic [7:0] start_tset, stop_tset, qset, sol_thr, ext_thr;
	logic [7:0] rate_v, run_v;

	assign program_level       = st.ctrl[ECC_F_PROGRAM_LEVEL +: 3];
	assign load_fn    = st.ctrl[ECC_F_LOADF +: 4];
	assign aux_fn     = st.ctrl[ECC_F_AUXF +: 4];
	assign sense_fn   = st.ctrl[ECC_F_SENSF +: 4];
	assign start_code = st.start_cfg[ECC_F_CODE +: 4];
	assign start_tset = st.start_cfg[ECC_F_TSET +: 8];
	assign stop_code  = st.stop_cfg[ECC_F_CODE +: 4];
	assign stop_tset  = st.stop_cfg[ECC_F_TSET +: 8];
	assign rate_v     = st.rate[7:0];
	assign run_v      = st.run[7:0];
	assign operating_state_qualifier       = st.qual[ECC_F_OPERATING_STATE_QUALIFIER +: 4];
	assign measured_qualifier       = st.qual[ECC_F_MEASURED_QUALIFIER +: 4];
	assign qset       = st.qual[ECC_F_QSET +: 8];
	assign sol_thr    = st.thresh[ECC_F_SOLT +: 8];
	assign ext_thr    = st.thresh[ECC_F_EXTT +: 8];

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] sel,
		input logic [31:0] msk);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i])
				r[8*i +: 8] = wd[8*i +: 8];
		end
		return r & msk;
	endfunction

	function automatic logic [10:0] scale(input logic [7:0] v,
		input logic hours);
		logic [10:0] w;
		w = {3'h0, v};
		return hours ? 11'(w * ECC_TENTH_H) : w;
	endfunction

	// ----------------------------------------
	// Conditions
	// ----------------------------------------
	logic enabled, ext_ok, pb_on, st_past, sp_past;
	logic start_c, stop_c, operating_state_qualifier_c, measured_qualifier_c, lbd_block;
	logic rs_en, rp_en, run_done;
	logic [10:0] rs_int, rp_int, run_min;
	logic [3:0]  tbase;

	always_comb begin
		enabled = program_level == ECC_PROGRAM_LEVEL_EVENT;
		ext_ok  = sense_fn == ECC_SENSE_EXT;
		pb_on   = meas.push_button_input;
		st_past = meas.time_of_day > start_tset;
		sp_past = meas.time_of_day > stop_tset;

		// Repeat start interval
		rs_en  = 1'b0;
		rs_int = 11'h000;
		unique case (start_code)
			4'd8:  begin rs_en = st_past; rs_int = ECC_RS_10M; end
			4'd9:  begin rs_en = st_past; rs_int = ECC_RS_30M; end
			4'd10: begin rs_en = st_past; rs_int = ECC_RS_1H;  end
			4'd11: begin rs_en = st_past; rs_int = ECC_RS_2H;  end
			4'd14: begin rs_en = 1'b1; rs_int = scale(rate_v, 1'b0); end
			4'd15: begin rs_en = 1'b1; rs_int = scale(rate_v, 1'b1); end
			default: ;
		endcase

		// Repeat stop interval
		rp_en  = 1'b0;
		rp_int = 11'h000;
		unique case (stop_code)
			4'd8:  begin rp_en = sp_past; rp_int = ECC_RP_1M;  end
			4'd9:  begin rp_en = sp_past; rp_int = ECC_RP_3M;  end
			4'd10: begin rp_en = sp_past; rp_int = ECC_RP_6M;  end
			4'd11: begin rp_en = sp_past; rp_int = ECC_RP_12M; end
			default: ;
		endcase

		run_min  = scale(run_v, stop_code == 4'd15);
		run_done = (stop_code == 4'd14 || stop_code == 4'd15)
			&& st.run_tmr >= run_min;

		// Unused codes fall to default and stay low
		unique case (start_code)
			4'd0:  start_c = st.solar_hi;
			4'd1:  start_c = st.solar_lo;
			4'd2:  start_c = ext_ok && meas.external_voltage > ext_thr;
			4'd3:  start_c = ext_ok && meas.external_voltage < ext_thr;
			4'd4:  start_c = ext_ok && pb_on && st_past;
			4'd5:  start_c = ext_ok && !pb_on && st_past;
			4'd12: start_c = st_past;
			4'd8, 4'd9, 4'd10, 4'd11, 4'd14, 4'd15:
				start_c = st.start_rep;
			default: start_c = 1'b0;
		endcase

		unique case (stop_code)
			4'd0:  stop_c = st.solar_hi;
			4'd1:  stop_c = st.solar_lo;
			4'd2:  stop_c = ext_ok && meas.external_voltage > ext_thr;
			4'd3:  stop_c = ext_ok && meas.external_voltage < ext_thr;
			4'd4:  stop_c = ext_ok && !pb_on && sp_past;
			4'd5:  stop_c = ext_ok && pb_on && sp_past;
			4'd12: stop_c = sp_past;
			4'd8, 4'd9, 4'd10, 4'd11:
				stop_c = st.stop_rep;
			4'd14, 4'd15:
				stop_c = run_done;
			default: stop_c = 1'b0;
		endcase

		unique case (operating_state_qualifier)
			4'd0: operating_state_qualifier_c = 1'b1;
			4'd1: operating_state_qualifier_c = meas.float_state;
			4'd2: operating_state_qualifier_c = meas.night;
			4'd3: operating_state_qualifier_c = !meas.night;
			4'd5: operating_state_qualifier_c = meas.float_state && meas.night;
			4'd6: operating_state_qualifier_c = meas.float_state && !meas.night;
			default: operating_state_qualifier_c = 1'b0;
		endcase

		// Codes 8..14 repeat 0..6 without the disconnect override
		tbase = {1'b0, measured_qualifier[2:0]};
		unique case (tbase)
			4'd0: measured_qualifier_c = 1'b1;
			4'd1: measured_qualifier_c = meas.temperature > qset;
			4'd2: measured_qualifier_c = meas.temperature < qset;
			4'd3: measured_qualifier_c = ext_ok && meas.external_voltage > qset;
			4'd4: measured_qualifier_c = ext_ok && meas.external_voltage < qset;
			4'd5: measured_qualifier_c = meas.time_of_day > qset;
			4'd6: measured_qualifier_c = meas.time_of_day < qset;
			default: measured_qualifier_c = 1'b0;
		endcase
		if (measured_qualifier == 4'd15)
			measured_qualifier_c = 1'b0;
		lbd_block = !measured_qualifier[3] && meas.low_battery_disconnect;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;

		// Bus: answer one cycle after the request
		next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
		if (next_st.ack) begin
			next_st.dat = 32'h0000_0000;
			unique case (wb_adr_i)
				ECC_ADR_CTRL:   next_st.dat = st.ctrl;
				ECC_ADR_START:  next_st.dat = st.start_cfg;
				ECC_ADR_STOP:   next_st.dat = st.stop_cfg;
				ECC_ADR_RATE:   next_st.dat = st.rate;
				ECC_ADR_RUN:    next_st.dat = st.run;
				ECC_ADR_QUAL:   next_st.dat = st.qual;
				ECC_ADR_THRESH: next_st.dat = st.thresh;
				ECC_ADR_STATUS: next_st.dat = {24'h0, st.term,
					enabled, measured_qualifier_c, operating_state_qualifier_c, stop_c, start_c,
					st.phase == ECC_ON};
				default: ;
			endcase
			if (wb_we_i) begin
				next_st.dat = 32'h0000_0000;
				unique case (wb_adr_i)
					ECC_ADR_CTRL: next_st.ctrl = merge(st.ctrl,
						wb_dat_i, wb_sel_i, ECC_MSK_CTRL);
					ECC_ADR_START: next_st.start_cfg = merge(
						st.start_cfg, wb_dat_i, wb_sel_i, ECC_MSK_CODE);
					ECC_ADR_STOP: next_st.stop_cfg = merge(
						st.stop_cfg, wb_dat_i, wb_sel_i, ECC_MSK_CODE);
					ECC_ADR_RATE: next_st.rate = merge(st.rate,
						wb_dat_i, wb_sel_i, ECC_MSK_BYTE);
					ECC_ADR_RUN: next_st.run = merge(st.run,
						wb_dat_i, wb_sel_i, ECC_MSK_BYTE);
					ECC_ADR_QUAL: next_st.qual = merge(st.qual,
						wb_dat_i, wb_sel_i, ECC_MSK_QUAL);
					ECC_ADR_THRESH: next_st.thresh = merge(st.thresh,
						wb_dat_i, wb_sel_i, ECC_MSK_THR);
					default: ;
				endcase
			end
		end

		// Solar compare refreshed once per period, hence the lag
		next_st.start_rep = 1'b0;
		next_st.stop_rep  = 1'b0;
		if (meas.minute_tick) begin
			if (st.solar_cnt >= SOLAR_PERIOD - 11'h001) begin
				next_st.solar_cnt = 11'h000;
				next_st.solar_hi  = meas.solar_voltage > sol_thr;
				next_st.solar_lo  = meas.solar_voltage < sol_thr;
			end else begin
				next_st.solar_cnt = st.solar_cnt + 11'h001;
			end
		end

		// Repeat timers; a zero interval never fires
		if (!rs_en || rs_int == 11'h000) begin
			next_st.start_tmr = 11'h000;
		end else if (meas.minute_tick) begin
			if (st.start_tmr + 11'h001 >= rs_int) begin
				next_st.start_tmr = 11'h000;
				next_st.start_rep = 1'b1;
			end else begin
				next_st.start_tmr = st.start_tmr + 11'h001;
			end
		end
		if (!rp_en) begin
			next_st.stop_tmr = 11'h000;
		end else if (meas.minute_tick) begin
			if (st.stop_tmr + 11'h001 >= rp_int) begin
				next_st.stop_tmr = 11'h000;
				next_st.stop_rep = 1'b1;
			end else begin
				next_st.stop_tmr = st.stop_tmr + 11'h001;
			end
		end

		// Event state
		unique case (st.phase)
			ECC_OFF: begin
				if (enabled && start_c && operating_state_qualifier_c && measured_qualifier_c)
					next_st.phase = ECC_ON;
			end
			ECC_ON: begin
				if (!enabled || stop_c || !operating_state_qualifier_c || !measured_qualifier_c)
					next_st.phase = ECC_OFF;
			end
		endcase

		// Run time counted from the start, saturating
		if (next_st.phase == ECC_OFF || st.phase == ECC_OFF)
			next_st.run_tmr = 11'h000;
		else if (meas.minute_tick && st.run_tmr != 11'h7ff)
			next_st.run_tmr = st.run_tmr + 11'h001;

		// Terminal drive
		next_st.term.load_event = st.phase == ECC_ON && !lbd_block
			&& (load_fn == ECC_FN_EVENT || load_fn == ECC_FN_EVENT_B);
		next_st.term.aux_event = st.phase == ECC_ON && !lbd_block
			&& (aux_fn == ECC_FN_EVENT || aux_fn == ECC_FN_EVENT_B);
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign wb_ack_o = st.ack;
	assign wb_dat_o = st.dat;
	assign term     = st.term;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_ack_single: assert property (st.ack |=> !st.ack)
		else $error("ack held longer than one cycle");
	a_ack_timely: assert property (
		wb_cyc_i && wb_stb_i && !st.ack |=> st.ack)
		else $error("request not answered next cycle");
	a_program_level_gate: assert property (!enabled |=> st.phase == ECC_OFF)
		else $error("event active outside program level 4");
	a_load_gate: assert property (st.term.load_event |->
		$past(load_fn) == ECC_FN_EVENT
		|| $past(load_fn) == ECC_FN_EVENT_B)
		else $error("load terminal driven with wrong function");
	a_turn_on: assert property (st.phase == ECC_OFF ##1
		st.phase == ECC_ON |-> $past(start_c && operating_state_qualifier_c && measured_qualifier_c))
		else $error("event started without all conditions");
	a_turn_off: assert property (st.phase == ECC_ON ##1
		st.phase == ECC_OFF |->
		$past(stop_c || !operating_state_qualifier_c || !measured_qualifier_c || !enabled))
		else $error("event stopped without cause");
	a_unused_start: assert property (start_code inside {4'd6, 4'd7,
		4'd13} |-> !start_c)
		else $error("unused start code asserted");
	a_rep_restart: assert property (st.start_rep |-> st.start_tmr == 0)
		else $error("repeat timer not restarted");
	a_float_qual: assert property (operating_state_qualifier == 4'd1 && !meas.float_state
		&& st.phase == ECC_ON |=> st.phase == ECC_OFF)
		else $error("event kept on outside float");
	a_qual_zero: assert property (st.phase == ECC_OFF && enabled
		&& operating_state_qualifier == 4'd0 && measured_qualifier == 4'd0 && start_c
		|=> st.phase == ECC_ON)
		else $error("zero qualifier blocked the start");

	c_start: cover property (st.phase == ECC_OFF ##1 st.phase == ECC_ON);
	c_stop_run: cover property (st.phase == ECC_ON && run_done);
	c_repeat: cover property (st.start_rep);
	c_lbd: cover property (st.phase == ECC_ON && lbd_block);

endmodule

// ==== rtl/ecc_pkg.sv ====
// Purpose: shared constants and types of the event controller
// Assumes: time of day in tenths of an hour, voltages in 0.1 V steps
// Notes:   register offsets are byte addresses on classic Wishbone
package ecc_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ECC_ADR_CTRL   = 8'h00;
	localparam logic [7:0] ECC_ADR_START  = 8'h04;
	localparam logic [7:0] ECC_ADR_STOP   = 8'h08;
	localparam logic [7:0] ECC_ADR_RATE   = 8'h0c;
	localparam logic [7:0] ECC_ADR_RUN    = 8'h10;
	localparam logic [7:0] ECC_ADR_QUAL   = 8'h14;
	localparam logic [7:0] ECC_ADR_THRESH = 8'h18;
	localparam logic [7:0] ECC_ADR_STATUS = 8'h1c;

	// Writable bits per register; the rest read zero
	localparam logic [31:0] ECC_MSK_CTRL  = 32'h0000_fff7;
	localparam logic [31:0] ECC_MSK_CODE  = 32'h0000_ff0f;
	localparam logic [31:0] ECC_MSK_BYTE  = 32'h0000_00ff;
	localparam logic [31:0] ECC_MSK_QUAL  = 32'h0000_ffff;
	localparam logic [31:0] ECC_MSK_THR   = 32'h0000_ffff;

	// Field positions
	localparam int ECC_F_PROGRAM_LEVEL  = 0;
	localparam int ECC_F_LOADF = 4;
	localparam int ECC_F_AUXF  = 8;
	localparam int ECC_F_SENSF = 12;
	localparam int ECC_F_CODE  = 0;
	localparam int ECC_F_TSET  = 8;
	localparam int ECC_F_OPERATING_STATE_QUALIFIER  = 0;
	localparam int ECC_F_MEASURED_QUALIFIER  = 4;
	localparam int ECC_F_QSET  = 8;
	localparam int ECC_F_SOLT  = 0;
	localparam int ECC_F_EXTT  = 8;

	// Settings that have meaning
	localparam logic [2:0] ECC_PROGRAM_LEVEL_EVENT = 3'h4;
	localparam logic [3:0] ECC_FN_EVENT   = 4'h4;
	localparam logic [3:0] ECC_FN_EVENT_B = 4'h5;
	localparam logic [3:0] ECC_SENSE_EXT  = 4'h2;
	localparam logic [7:0] ECC_EXTERNAL_VOLTAGE_ZERO  = 8'h50;

	// Timing in minutes
	localparam logic [10:0] ECC_SOLAR_MIN = 11'h006;
	localparam logic [10:0] ECC_RS_10M    = 11'h00a;
	localparam logic [10:0] ECC_RS_30M    = 11'h01e;
	localparam logic [10:0] ECC_RS_1H     = 11'h03c;
	localparam logic [10:0] ECC_RS_2H     = 11'h078;
	localparam logic [10:0] ECC_RP_1M     = 11'h001;
	localparam logic [10:0] ECC_RP_3M     = 11'h003;
	localparam logic [10:0] ECC_RP_6M     = 11'h006;
	localparam logic [10:0] ECC_RP_12M    = 11'h00c;
	localparam logic [10:0] ECC_TENTH_H   = 11'h006;

	typedef enum logic {ECC_OFF, ECC_ON} ecc_phase_e;

	// Measurements arriving from the regulator core
	typedef struct packed {
		logic [7:0] solar_voltage;
		logic [7:0] external_voltage;
		logic [7:0] temperature;
		logic [7:0] time_of_day;
		logic       push_button_input;
		logic       float_state;
		logic       night;
		logic       low_battery_disconnect;
		logic       minute_tick;
	} ecc_meas_s;

	typedef struct packed {
		logic load_event;
		logic aux_event;
	} ecc_term_s;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] start_cfg;
		logic [31:0] stop_cfg;
		logic [31:0] rate;
		logic [31:0] run;
		logic [31:0] qual;
		logic [31:0] thresh;
		ecc_phase_e  phase;
		logic [10:0] solar_cnt;
		logic        solar_hi;
		logic        solar_lo;
		logic [10:0] start_tmr;
		logic [10:0] stop_tmr;
		logic [10:0] run_tmr;
		logic        start_rep;
		logic        stop_rep;
		logic        ack;
		logic [31:0] dat;
		ecc_term_s   term;
	} ecc_state_s;

endpackage

// ==== sim/ecc_far_side.sv ====
// Purpose: push-button contact seen on the sense input
// Assumes: contact wired from sense input to battery negative
// Notes:   contact follows the bench command one clock later
`timescale 1ns/1ps

module ecc_far_side
	import ecc_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic sys_rst,
	// Bench command
	input  wire logic press,
	// Contact level
	output logic      button
);
	// Closed contact reads 1; registered like a real input stage
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			button <= 1'b0;
		end else begin
			button <= press;
		end
	end
endmodule

// ==== sim/tb.sv ====
// Purpose: self-checking bench for the event controller
// Assumes: status bits 0 on, 3 op qual, 4 meas qual, 5 on-enable, 7 load
// Notes:   solar refresh shortened to two minute ticks
`timescale 1ns/1ps

module tb
	import ecc_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clock;
	logic        sys_rst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic        ack;
	logic [31:0] rdat;
	ecc_meas_s   m;
	ecc_meas_s   mw;
	ecc_term_s   term;
	logic        press;
	logic        button;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int          bad_count;
	int          num_checks;
	int          cycles;
	int          seed;
	logic [31:0] d;
	logic        q;
	logic [10:0] iv[6] = '{ECC_RS_10M, ECC_RS_30M, ECC_RS_1H, ECC_RS_2H,
		11'h005, ECC_TENTH_H};
	logic [31:0] cd[6] = '{32'h8, 32'h9, 32'ha, 32'hb, 32'he, 32'hf};

	assign mw = {m[36:5], button, m[3:0]};

	ecc_event_ctrl #(
		.SOLAR_PERIOD (11'h002)
	) ecc_event_ctrl_inst (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.wb_cyc_i (cyc),
		.wb_stb_i (stb),
		.wb_we_i  (we),
		.wb_adr_i (adr),
		.wb_sel_i (sel),
		.wb_dat_i (wdat),
		.wb_ack_o (ack),
		.wb_dat_o (rdat),
		.meas     (mw),
		.term     (term)
	);

	ecc_far_side ecc_far_side_inst (
		.clock   (clock),
		.sys_rst (sys_rst),
		.press   (press),
		.button  (button)
	);

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, want, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Expected read data is noted before the request goes out
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] wd,
		input logic [31:0] e, input logic [31:0] k);
		int n;
		exp_q.push_back(e & k);
		msk_q.push_back(k);
		@(posedge clock);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		sel  <= s;
		wdat <= wd;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1 && n < 40);
		if (n == 40) check("ack wait", 32'h0, 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		bus(1'b1, a, 4'hf, wd, 32'h0, 32'hffff_ffff);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] k);
		bus(1'b0, a, 4'hf, 32'h0, e, k);
	endtask

	// Lets condition, phase and terminal registers settle first
	task automatic st(input logic [7:0] e, input logic [7:0] k);
		repeat (3) @(posedge clock);
		rd(ECC_ADR_STATUS, {24'h0, e}, {24'h0, k});
		check("terminals", {30'h0, term}, {30'h0, e[7:6]});
	endtask

	task automatic restart(input logic [31:0] c);
		wr(ECC_ADR_CTRL, c & 32'hffff_fff8);
		wr(ECC_ADR_CTRL, c);
	endtask

	task automatic tick(input logic [10:0] n);
		repeat (n) begin
			@(posedge clock);
			m.minute_tick <= 1'b1;
			@(posedge clock);
			m.minute_tick <= 1'b0;
		end
	endtask

	// ----------------------------------------
	// Clock, monitor and timeout
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			results();
		end
		if (ack === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("unexpected ack", 32'h1, 32'h0);
			end else begin
				check("read data", rdat & msk_q.pop_front(), exp_q.pop_front());
			end
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		seed = 53496;
		sys_rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0;
		m = '0;
		press = 1'b0;
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		rd(ECC_ADR_CTRL, 32'h0, 32'hffff_ffff);
		wr(ECC_ADR_STATUS, 32'hffff_ffff);
		rd(ECC_ADR_STATUS, 32'h18, 32'hffff_ffff);
		rd(8'h20, 32'h0, 32'hffff_ffff);
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			wr(ECC_ADR_THRESH, d);
			rd(ECC_ADR_THRESH, d & ECC_MSK_THR, 32'hffff_ffff);
		end
		bus(1'b1, ECC_ADR_THRESH, 4'h2, 32'hffff_ffff, 32'h0, 32'hffff_ffff);
		rd(ECC_ADR_THRESH, (d & 32'h00ff) | 32'hff00, 32'hffff_ffff);
		m.time_of_day <= 8'h64;
		wr(ECC_ADR_START, 32'h0000_000c);
		wr(ECC_ADR_STOP, 32'h0000_fc0c);
		wr(ECC_ADR_QUAL, 32'h0);
		for (int i = 0; i < 5; i++) begin
			wr(ECC_ADR_CTRL, 32'h40 | 32'(i));
			st((i == 4) ? 8'ha1 : 8'h00, 8'he1);
		end
		for (int i = 0; i < 8; i++) begin
			wr(ECC_ADR_CTRL, 32'h4 | (32'(i) << 4) | (32'(i) << 8));
			q = (i == 4 || i == 5);
			st({q, q, 6'h21}, 8'he1);
		end
		wr(ECC_ADR_CTRL, 32'h44);
		m.low_battery_disconnect <= 1'b1;
		st(8'h21, 8'he1);
		wr(ECC_ADR_QUAL, 32'h80);
		st(8'ha1, 8'he1);
		m.low_battery_disconnect <= 1'b0;
		wr(ECC_ADR_QUAL, 32'h0);
		wr(ECC_ADR_START, 32'h640c);
		restart(32'h44);
		st(8'h20, 8'he1);
		m.time_of_day <= 8'h65;
		st(8'ha1, 8'he1);
		wr(ECC_ADR_START, 32'h0d);
		m.time_of_day <= 8'hef;
		wr(ECC_ADR_STOP, 32'hef0c);
		st(8'ha1, 8'he1);
		wr(ECC_ADR_STOP, 32'h640c);
		st(8'h20, 8'he1);
		wr(ECC_ADR_START, 32'h0c);
		wr(ECC_ADR_STOP, 32'hfc0c);
		for (int i = 0; i < 16; i++) begin
			d = $random(seed);
			m.float_state <= d[0];
			m.night <= d[1];
			wr(ECC_ADR_QUAL, 32'(i));
			restart(32'h44);
			case (i)
				0: q = 1'b1;
				1: q = d[0];
				2: q = d[1];
				3: q = !d[1];
				5: q = d[0] & d[1];
				6: q = d[0] & !d[1];
				default: q = 1'b0;
			endcase
			st({q, 2'b01, 1'b1, q, 2'b00, q}, 8'hf9);
		end
		wr(ECC_ADR_QUAL, 32'h0);
		wr(ECC_ADR_START, 32'h04);
		wr(ECC_ADR_STOP, 32'h04);
		press <= 1'b1;
		restart(32'h44);
		st(8'h20, 8'he1);
		wr(ECC_ADR_CTRL, 32'h2044);
		for (int c = 4; c < 6; c++) begin
			wr(ECC_ADR_START, 32'(c));
			wr(ECC_ADR_STOP, 32'(c));
			press <= (c == 4);
			st(8'ha1, 8'he1);
			press <= (c == 5);
			st(8'h20, 8'he1);
		end
		wr(ECC_ADR_RUN, 32'h3);
		wr(ECC_ADR_STOP, 32'h0e);
		wr(ECC_ADR_START, 32'h04);
		press <= 1'b0;
		st(8'ha1, 8'he1);
		tick(11'h002);
		st(8'ha1, 8'he1);
		tick(11'h001);
		st(8'h20, 8'he1);
		wr(ECC_ADR_STOP, 32'hfc0c);
		wr(ECC_ADR_THRESH, 32'h6400);
		m.external_voltage <= 8'h64;
		wr(ECC_ADR_START, 32'h02);
		restart(32'h2044);
		st(8'h20, 8'he1);
		m.external_voltage <= 8'h65;
		st(8'ha1, 8'he1);
		wr(ECC_ADR_THRESH, 32'h80);
		for (int c = 0; c < 2; c++) begin
			m.solar_voltage <= (c == 1) ? 8'h7f : 8'h81;
			wr(ECC_ADR_START, 32'(c));
			wr(ECC_ADR_STOP, 32'hfc0c);
			restart(32'h2044);
			tick(11'h002);
			st(8'ha1, 8'he1);
			wr(ECC_ADR_STOP, 32'(1 - c));
			m.solar_voltage <= (c == 1) ? 8'h81 : 8'h7f;
			tick(11'h002);
			st(8'h20, 8'he1);
		end
		wr(ECC_ADR_STOP, 32'hfc0c);
		for (int i = 0; i < 6; i++) begin
			wr(ECC_ADR_RATE, (i == 4) ? 32'h5 : 32'h1);
			wr(ECC_ADR_START, cd[i]);
			restart(32'h2044);
			tick(iv[i]);
			st(8'ha1, 8'he1);
		end
		wr(ECC_ADR_STOP, 32'h08);
		tick(11'h001);
		st(8'h20, 8'he1);
		wr(ECC_ADR_STOP, 32'hfc0c);
		wr(ECC_ADR_START, 32'h0c);
		wr(ECC_ADR_QUAL, 32'hf050);
		st(8'h28, 8'hf9);
		wr(ECC_ADR_QUAL, 32'he050);
		st(8'hb9, 8'hf9);
		results();
	end
endmodule
